//--- ucr_defines.vh
`ifndef UCR_DEFINES_VH
`define UCR_DEFINES_VH

// Control register field positions.
`define UCR_BIT_LSB_FIRST 0
`define UCR_BIT_SDIO_IN_ONLY 1
`define UCR_BIT_AUTO_PD 2
`define UCR_BIT_EXT_PD_FAST 3
`define UCR_BIT_AUX_DAC_PD 4
`define UCR_BIT_REF_PD 5
`define UCR_BIT_DAC_PD 6
`define UCR_BIT_DIG_PD 7
`define UCR_BIT_AUTO_OSK 8
`define UCR_BIT_OSK_EN 9
`define UCR_BIT_LOAD_ARR 10
`define UCR_BIT_CLR_PHASE 11
`define UCR_BIT_AUTOCLR_PHASE 13
`define UCR_BIT_SEL_SINE 16
`define UCR_MODE_HI 25
`define UCR_MODE_LO 24

// Register geometry and reset value.
`define UCR_REG_W 32
`define UCR_REG_RESET 32'h0000_0000
`define UCR_INSTR_W 8
`define UCR_ADDR_W 5
`define UCR_ADDR_CFR 5'h00
`define UCR_BYTES_CFR 3'h4
`define UCR_CNT_W 6
`define UCR_CNT_DATA 6'd8
`define UCR_CNT_RD_LOAD 6'd7
`define UCR_CNT_LAST 6'd39

// Operating mode encodings.
`define UCR_MODE_QUAD 2'h0
`define UCR_MODE_SINGLE 2'h1

`endif

//--- ucr_sync2.v
`timescale 1ns/1ps
module ucr_sync2 (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_async,
  output reg o_sync
);
  reg meta;

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // ucr_sync2

//--- ucr_serial_port.v
`timescale 1ns/1ps
`include "ucr_defines.vh"
// Serial port shifter. Takes synchronised pin levels, emits one word write per write
// instruction and shifts read data back out on reads. Bit order and wiring follow the
// two mode inputs.
module ucr_serial_port (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_sdio,
  input wire i_lsb_first,
  input wire i_in_only,
  input wire [`UCR_REG_W-1:0] i_rd_data,
  output reg o_wr_stb,
  output reg [`UCR_ADDR_W-1:0] o_addr,
  output reg [`UCR_REG_W-1:0] o_wr_data,
  output reg o_sdio_out,
  output reg o_sdio_oe_n,
  output reg o_sdo
);
  reg sclk_d;
  reg [`UCR_CNT_W-1:0] cnt;
  reg [`UCR_INSTR_W-1:0] instr;
  reg [`UCR_REG_W-1:0] shreg;
  reg [`UCR_REG_W-1:0] rd_sh;
  wire rise;
  wire fall;
  wire is_read;
  wire in_data;

  assign rise = i_sclk & ~sclk_d;
  assign fall = ~i_sclk & sclk_d;
  assign is_read = instr[`UCR_INSTR_W-1];
  assign in_data = (cnt >= `UCR_CNT_DATA);

  // Shift one bit into a word in the selected order.
  function [`UCR_REG_W-1:0] shift_in;
    input [`UCR_REG_W-1:0] w;
    input b;
    input lsb;
    begin
      if (lsb)
        shift_in = {b, w[`UCR_REG_W-1:1]};
      else
        shift_in = {w[`UCR_REG_W-2:0], b};
    end
  endfunction

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_d <= 1'b0;
      cnt <= 6'h00;
      instr <= 8'h00;
      shreg <= 32'h0000_0000;
      rd_sh <= 32'h0000_0000;
      o_wr_stb <= 1'b0;
      o_addr <= 5'h00;
      o_wr_data <= 32'h0000_0000;
      o_sdio_out <= 1'b0;
      o_sdio_oe_n <= 1'b1;
      o_sdo <= 1'b0;
    end else begin
      sclk_d <= i_sclk;
      o_wr_stb <= 1'b0;
      if (i_cs_n) begin
        cnt <= 6'h00;
        o_sdio_oe_n <= 1'b1;
      end else begin
        if (rise) begin
          cnt <= cnt + 6'h01;
          if (!in_data) begin
            if (i_lsb_first) // [R14]
              instr <= {i_sdio, instr[`UCR_INSTR_W-1:1]};
            else
              instr <= {instr[`UCR_INSTR_W-2:0], i_sdio};
          end else if (!is_read) begin
            shreg <= shift_in(shreg, i_sdio, i_lsb_first); // [R14]
            if (cnt == `UCR_CNT_LAST) begin
              o_wr_stb <= 1'b1;
              o_addr <= instr[`UCR_ADDR_W-1:0];
              o_wr_data <= shift_in(shreg, i_sdio, i_lsb_first);
            end
          end
          if (cnt == `UCR_CNT_RD_LOAD)
            rd_sh <= i_rd_data;
        end
        if (fall && in_data && is_read) begin
          o_sdio_out <= i_lsb_first ? rd_sh[0] : rd_sh[`UCR_REG_W-1]; // [R14]
          o_sdo <= i_lsb_first ? rd_sh[0] : rd_sh[`UCR_REG_W-1];
          rd_sh <= i_lsb_first ? {1'b0, rd_sh[`UCR_REG_W-1:1]} : {rd_sh[`UCR_REG_W-2:0], 1'b0};
          o_sdio_oe_n <= i_in_only; // [R13]
        end
      end
    end
  end
endmodule // ucr_serial_port

//--- ucr_ctrl.v
// What this block does
// R01: Bit 16 routes the sine output when set and cosine when clear, only in single tone mode.
// R02: Bit 13 clears the phase accumulator on every update strobe or profile change.
// R03: Bit 11 holds the phase accumulator cleared for as long as it is set.
// R04: Bit 10 reloads the amplitude ramp timer on every update strobe or profile change.
// R05: Bit 9 enables output shift keying, and is clear after reset.
// R06: Bit 8 picks automatic over manual keying, only while bit 9 is set.
// R07: Bit 7 stops the digital core clocks at once on write, with no update strobe.
// R08: Bit 6 powers down the main DAC clocks and bias, clear after reset.
// R09: Bit 5 powers down the reference clock input and PLL at once on write.
// R10: Bit 4 powers down the auxiliary DAC clocks and bias, clear after reset.
// R11: Bit 3 makes the external power-down pin give fast recovery instead of full power-down.
// R12: Bit 2 outside single tone mode stops and flushes the baseband chain while transmit enable is low.
// R13: Bit 1 makes the serial data pin input only (three wire) when set, bidirectional when clear.
// R14: Bit 0 shifts the serial port least significant bit first when set, most first when clear.
// R15: Mode bits 25:24 encode quadrature as 00, single tone as 01 and interpolating DAC as 1x.
// R16: All other fields are buffered on write and take effect on the update strobe.
`timescale 1ns/1ps
`include "ucr_defines.vh"
module ucr_ctrl (
  input wire i_mclk,
  input wire i_sys_rst,
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_sdio,
  input wire i_io_update,
  input wire [2:0] i_profile,
  input wire i_external_powerdown_pin,
  input wire i_transmit_enable_pin,
  output reg o_sdio_out,
  output reg o_sdio_oe_n,
  output reg o_sdo,
  output reg [1:0] o_mode,
  output reg o_sel_sine,
  output reg o_phase_acc_clr,
  output reg o_arr_reload,
  output reg o_osk_en,
  output reg o_osk_auto,
  output reg o_dig_clk_stop,
  output reg o_dac_pd,
  output reg o_ref_pd,
  output reg o_aux_dac_pd,
  output reg o_full_pd,
  output reg o_fast_pd,
  output reg o_bb_flush
);
  wire cs_n_s;
  wire sclk_s;
  wire sdio_s;
  wire upd_s;
  wire ext_pd_s;
  wire tx_en_s;
  wire [2:0] prof_s;
  wire wr_stb;
  wire [`UCR_ADDR_W-1:0] wr_addr;
  wire [`UCR_REG_W-1:0] wr_data;
  wire sp_out;
  wire sp_oe_n;
  wire sp_sdo;
  reg [`UCR_REG_W-1:0] shadow;
  reg [`UCR_REG_W-1:0] active;
  reg upd_d;
  reg [2:0] prof_d;
  wire upd_rise;
  wire prof_chg;
  wire cfr_wr;
  wire single_tone;

  ucr_sync2 u_s_cs (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_async(i_cs_n), .o_sync(cs_n_s));
  ucr_sync2 u_s_ck (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_async(i_sclk), .o_sync(sclk_s));
  ucr_sync2 u_s_io (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_async(i_sdio), .o_sync(sdio_s));
  ucr_sync2 u_s_up (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_async(i_io_update), .o_sync(upd_s));
  ucr_sync2 u_s_pd (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_async(i_external_powerdown_pin),
    .o_sync(ext_pd_s));
  ucr_sync2 u_s_tx (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_async(i_transmit_enable_pin),
    .o_sync(tx_en_s));
  ucr_sync2 u_s_p0 (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_async(i_profile[0]), .o_sync(prof_s[0]));
  ucr_sync2 u_s_p1 (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_async(i_profile[1]), .o_sync(prof_s[1]));
  ucr_sync2 u_s_p2 (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_async(i_profile[2]), .o_sync(prof_s[2]));

  // Port mode bits come from the active copy, so a new wiring or bit order
  // applies from the first instruction after the update strobe.
  ucr_serial_port u_port (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_cs_n(cs_n_s),
    .i_sclk(sclk_s),
    .i_sdio(sdio_s),
    .i_lsb_first(active[`UCR_BIT_LSB_FIRST]), // [R14][R16]
    .i_in_only(active[`UCR_BIT_SDIO_IN_ONLY]), // [R13][R16]
    .i_rd_data(shadow),
    .o_wr_stb(wr_stb),
    .o_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_sdio_out(sp_out),
    .o_sdio_oe_n(sp_oe_n),
    .o_sdo(sp_sdo)
  );

  assign upd_rise = upd_s & ~upd_d;
  assign prof_chg = (prof_s != prof_d);
  assign cfr_wr = wr_stb && (wr_addr == `UCR_ADDR_CFR);
  assign single_tone = (active[`UCR_MODE_HI:`UCR_MODE_LO] == `UCR_MODE_SINGLE); // [R15]

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shadow <= `UCR_REG_RESET;
      active <= `UCR_REG_RESET;
      upd_d <= 1'b0;
      prof_d <= 3'h0;
    end else begin
      upd_d <= upd_s;
      prof_d <= prof_s;
      if (cfr_wr)
        shadow <= wr_data;
      if (upd_rise)
        active <= shadow; // [R16]
      // Immediate bits track the written value without a strobe.
      if (cfr_wr) begin
        active[`UCR_BIT_DIG_PD] <= wr_data[`UCR_BIT_DIG_PD]; // [R07]
        active[`UCR_BIT_REF_PD] <= wr_data[`UCR_BIT_REF_PD]; // [R09]
      end
    end
  end

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sdio_out <= 1'b0;
      o_sdio_oe_n <= 1'b1;
      o_sdo <= 1'b0;
      o_mode <= 2'h0;
      o_sel_sine <= 1'b0;
      o_phase_acc_clr <= 1'b0;
      o_arr_reload <= 1'b0;
      o_osk_en <= 1'b0;
      o_osk_auto <= 1'b0;
      o_dig_clk_stop <= 1'b0;
      o_dac_pd <= 1'b0;
      o_ref_pd <= 1'b0;
      o_aux_dac_pd <= 1'b0;
      o_full_pd <= 1'b0;
      o_fast_pd <= 1'b0;
      o_bb_flush <= 1'b0;
    end else begin
      o_sdio_out <= sp_out;
      o_sdio_oe_n <= sp_oe_n | active[`UCR_BIT_SDIO_IN_ONLY]; // [R13]
      o_sdo <= sp_sdo;
      o_mode <= active[`UCR_MODE_HI:`UCR_MODE_LO]; // [R15]
      o_sel_sine <= single_tone & active[`UCR_BIT_SEL_SINE]; // [R01]
      o_phase_acc_clr <= active[`UCR_BIT_CLR_PHASE] | // [R03]
        (active[`UCR_BIT_AUTOCLR_PHASE] & (upd_rise | prof_chg)); // [R02]
      o_arr_reload <= active[`UCR_BIT_LOAD_ARR] & (upd_rise | prof_chg); // [R04]
      o_osk_en <= active[`UCR_BIT_OSK_EN]; // [R05]
      o_osk_auto <= active[`UCR_BIT_OSK_EN] & active[`UCR_BIT_AUTO_OSK]; // [R06]
      o_dig_clk_stop <= active[`UCR_BIT_DIG_PD]; // [R07]
      o_dac_pd <= active[`UCR_BIT_DAC_PD]; // [R08]
      o_ref_pd <= active[`UCR_BIT_REF_PD]; // [R09]
      o_aux_dac_pd <= active[`UCR_BIT_AUX_DAC_PD]; // [R10]
      o_full_pd <= ext_pd_s & ~active[`UCR_BIT_EXT_PD_FAST]; // [R11]
      o_fast_pd <= ext_pd_s & active[`UCR_BIT_EXT_PD_FAST]; // [R11]
      o_bb_flush <= active[`UCR_BIT_AUTO_PD] & ~single_tone & ~tx_en_s; // [R12]
    end
  end
endmodule // ucr_ctrl

//--- ucr_ctrl_chk.sv
`timescale 1ns/1ps
module ucr_ctrl_chk (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_io_update,
  input wire logic [2:0] i_profile,
  input wire logic [1:0] o_mode,
  input wire logic o_sel_sine,
  input wire logic o_phase_acc_clr,
  input wire logic o_arr_reload,
  input wire logic o_osk_en,
  input wire logic o_osk_auto,
  input wire logic o_dac_pd,
  input wire logic o_aux_dac_pd,
  input wire logic o_full_pd,
  input wire logic o_fast_pd,
  input wire logic o_bb_flush
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic [3:0] age;
  logic [2:0] prof_q;
  // Counts cycles since the last update strobe or profile change, saturating.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      age <= 4'hf;
      prof_q <= 3'h0;
    end else begin
      prof_q <= i_profile;
      age <= (i_io_update || i_profile != prof_q) ? 4'h0 : age + {3'h0, age != 4'hf};
    end
  end
  sequence s_pulse;
    o_arr_reload ##1 !o_arr_reload;
  endsequence
  AST_SINE: assert property (o_sel_sine |-> o_mode == 2'h1)
    else $error("sine selected outside single tone");
  AST_AUTO: assert property (o_osk_auto |-> o_osk_en)
    else $error("auto keying without keying enabled");
  AST_PDX: assert property (!(o_full_pd && o_fast_pd))
    else $error("both power-down kinds at once");
  AST_BB: assert property (o_bb_flush |-> o_mode != 2'h1)
    else $error("baseband flush in single tone");
  AST_ARR_ONE: assert property (o_arr_reload |-> s_pulse)
    else $error("ramp reload longer than one cycle");
  AST_ARR_CAUSE: assert property ($rose(o_arr_reload) |-> age < 4'h8)
    else $error("ramp reload without update or profile change");
  AST_CLR_CAUSE: assert property ($rose(o_phase_acc_clr) |-> age < 4'h8)
    else $error("phase clear without update or profile change");
  AST_HELD: assert property ($changed({o_mode, o_sel_sine, o_osk_en, o_osk_auto, o_dac_pd, o_aux_dac_pd})
    |-> age < 4'hc)
    else $error("buffered control changed without update");
endmodule // ucr_ctrl_chk
bind ucr_ctrl ucr_ctrl_chk chk (.i_mclk, .i_sys_rst, .i_io_update, .i_profile, .o_mode, .o_sel_sine,
  .o_phase_acc_clr, .o_arr_reload, .o_osk_en, .o_osk_auto, .o_dac_pd, .o_aux_dac_pd, .o_full_pd, .o_fast_pd,
  .o_bb_flush);

//--- ucr_host.sv
`timescale 1ns/1ps
module ucr_host (
  input wire logic i_mclk,
  input wire logic i_sdio_out,
  input wire logic i_sdo,
  input wire logic i_sdio_oe_n,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdio
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdio = 1'b0;
  end
  // After a read instruction the host only listens on the device's outputs.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic lsb);
    logic [39:0] w;
    w = {3'h0, a, d};
    @(posedge i_mclk) o_cs_n <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      repeat (4) @(posedge i_mclk);
      o_sclk <= 1'b0;
      o_sdio <= lsb ? w[i < 8 ? 32 + i : i - 8] : w[39 - i];
      repeat (4) @(posedge i_mclk);
      o_sclk <= 1'b1;
    end
    repeat (4) @(posedge i_mclk);
    o_sclk <= 1'b0;
    repeat (4) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    o_sdio <= ~o_sdio;
  endtask
  // Each read bit is taken one full serial clock after the fall that launched it.
  task automatic rd(input logic [4:0] a, input logic lsb, output logic [64:0] got);
    logic [7:0] ins;
    ins = {3'h4, a};
    got = '0;
    @(posedge i_mclk) o_cs_n <= 1'b0;
    for (int i = 0; i < 41; i++) begin
      repeat (4) @(posedge i_mclk);
      if (i > 8)
        got = lsb ? {got[64], i_sdio_out, got[63:33], i_sdo, got[31:1]} :
          {got[64], got[62:32], i_sdio_out, got[30:0], i_sdo};
      if (i == 20)
        got[64] = i_sdio_oe_n;
      o_sclk <= 1'b0;
      if (i < 8)
        o_sdio <= lsb ? ins[i] : ins[7 - i];
      if (i < 40) begin
        repeat (4) @(posedge i_mclk);
        o_sclk <= 1'b1;
      end
    end
    repeat (4) @(posedge i_mclk);
    o_cs_n <= 1'b1;
  endtask
endmodule // ucr_host

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_mclk, i_sys_rst, i_cs_n, i_sclk, i_sdio, i_io_update, zap;
  logic i_external_powerdown_pin, i_transmit_enable_pin;
  logic [2:0] i_profile, na, nc;
  logic o_sdio_out, o_sdio_oe_n, o_sdo, o_sel_sine, o_phase_acc_clr, o_arr_reload, o_osk_en, o_osk_auto;
  logic o_dig_clk_stop, o_dac_pd, o_ref_pd, o_aux_dac_pd, o_full_pd, o_fast_pd, o_bb_flush;
  logic [1:0] o_mode;
  logic [31:0] act, sh, w;
  logic [37:0] q[$];
  logic [64:0] rq[$], got;
  event rd_ev;
  int failures = 0;
  int n_checks = 0;
  int seed = 5989;
  ucr_ctrl dut (.*);
  ucr_host host (.i_mclk, .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_sdio(i_sdio), .i_sdio_out(o_sdio_out), .i_sdo(o_sdo),
    .i_sdio_oe_n(o_sdio_oe_n));
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  function automatic logic [12:0] ex(input logic [31:0] a, s, input logic e, t);
    ex = {a[25:24], a[16] && a[25:24] == 2'h1, a[9], a[9] && a[8], s[7], a[6], s[5], a[4],
      e && !a[3], e && a[3], a[2] && a[25:24] != 2'h1 && !t, 1'b1};
  endfunction
  task automatic chk(input logic [64:0] s, e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic put(input logic [5:0] c, input logic [18:0] m);
    q.push_back({m, c, ex(act, sh, i_external_powerdown_pin, i_transmit_enable_pin)});
  endtask
  task automatic clr;
    wait (q.size() == 0);
    @(posedge i_mclk) zap <= 1'b1;
    @(posedge i_mclk) zap <= 1'b0;
  endtask
  task automatic test_done;
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    na <= zap ? 3'h0 : na + {2'h0, o_arr_reload && na != 3'h7};
    nc <= zap ? 3'h0 : nc + {2'h0, o_phase_acc_clr && nc != 3'h7};
  end
  initial forever begin
    wait (q.size() > 0);
    repeat (14) @(posedge i_mclk);
    chk({na, nc, o_mode, o_sel_sine, o_osk_en, o_osk_auto, o_dig_clk_stop, o_dac_pd, o_ref_pd, o_aux_dac_pd,
      o_full_pd, o_fast_pd, o_bb_flush, o_sdio_oe_n} & q[0][37:19], q[0][18:0] & q[0][37:19]);
    void'(q.pop_front());
  end
  initial forever begin
    @(rd_ev);
    chk(got, rq[0]);
    void'(rq.pop_front());
  end
  initial begin
    #1000000;
    failures++;
    test_done;
  end
  initial begin
    i_sys_rst = 1'b1;
    {i_io_update, zap, i_external_powerdown_pin, i_transmit_enable_pin, i_profile, act, sh} = '0;
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    clr;
    put(6'h00, 19'h7ffff);
    for (int i = 0; i < 12; i++) begin
      w = i == 0 ? 32'h0101_0204 : $random(seed) & 32'h0301_2fff;
      clr;
      i_external_powerdown_pin <= $random(seed);
      i_transmit_enable_pin <= $random(seed);
      // The last write goes to another address and must leave the register alone.
      host.wr(i == 11 ? 5'h03 : 5'h00, w, act[0]);
      if (i != 11)
        sh = w;
      put({3'h0, act[11] ? 3'h7 : 3'h0}, 19'h7ffff);
      clr;
      i_io_update <= 1'b1;
      repeat (3) @(posedge i_mclk);
      i_io_update <= 1'b0;
      act = sh;
      put(6'h00, 19'h01fff);
      clr;
      rq.push_back({act[1], sh, sh});
      host.rd(5'h00, act[0], got);
      -> rd_ev;
      i_profile <= i_profile + 3'h1;
      put({2'h0, act[10], act[11] ? 3'h7 : {2'h0, act[13]}}, 19'h7ffff);
    end
    wait (q.size() == 0);
    test_done;
  end
endmodule // tb_top
